/* File: rtl/eis_pkg.sv */
// Constants for the two-wire memory slave select front end
package eis_pkg;
    // ----------------------------------------
    // Geometry and select byte layout
    // ----------------------------------------
    localparam int EIS_WIDE_BYTES = 65536;
    localparam int EIS_NARROW_BYTES = 32768;
    localparam int EIS_DATA_W = 8;
    localparam int EIS_TYPE_HI = 7;
    localparam int EIS_TYPE_LO = 4;
    localparam int EIS_STRAP_HI = 3;
    localparam int EIS_STRAP_LO = 1;
    localparam int EIS_RW_BIT = 0;
    // Type nibble value is arbitrary, set per product
    localparam logic [3:0] EIS_TYPE_ID = 4'h5;
    localparam logic [3:0] EIS_BIT_RESET = 4'h0;
    localparam logic [3:0] EIS_ACK_SLOT = 4'h8;
    localparam logic [7:0] EIS_BYTE_RESET = 8'h00;
    localparam logic [15:0] EIS_ADDR_RESET = 16'h0000;
    localparam logic [1:0] EIS_ADDR_BYTES = 2'h2;
    // ----------------------------------------
    // Bus states
    // ----------------------------------------
    typedef enum logic [2:0] {
        EIS_IDLE,
        EIS_SELECT,
        EIS_ADDR,
        EIS_WDATA,
        EIS_RDATA
    } eis_state_e;
endpackage

/* File: rtl/eis_slave.sv */
// Two-wire serial memory slave: start/stop, select decode, acknowledge, array
`timescale 1ns/100ps
module eis_slave
    import eis_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic strap_select_bit0,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit2,
    input wire logic write_inhibit_input,
    output logic program_start,
    output logic selected
);
    localparam int DEPTH = LARGE ? EIS_WIDE_BYTES : EIS_NARROW_BYTES;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic [4:0] pin_meta_reg, pin_sync_reg;
    logic scl_prev_reg, sda_prev_reg;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else if (clk_en) begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            pin_meta_reg <= {write_inhibit_input, strap_select_bit2, strap_select_bit1, strap_select_bit0, 1'b0};
            pin_sync_reg <= pin_meta_reg;
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic [2:0] strap_s;
    logic inhibit_s;
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    // Start/stop only while the clock stays high
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
    // Pads pull straps and inhibit low when floating, so open reads zero
    assign strap_s = pin_sync_reg[3:1];
    assign inhibit_s = pin_sync_reg[4];

    // Select decode, used for every received select byte
    function automatic logic sel_match(input logic [7:0] b, input logic [2:0] s);
        sel_match = (b[EIS_TYPE_HI:EIS_TYPE_LO] == EIS_TYPE_ID)
            && (b[EIS_STRAP_HI:EIS_STRAP_LO] == s);
    endfunction

    // ----------------------------------------
    // Bit and byte sequencing
    // ----------------------------------------
    eis_state_e state_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg, tx_reg;
    logic ack_reg, wrote_reg, master_nack_reg;
    logic [1:0] addr_cnt_reg;
    logic [15:0] addr_reg;
    logic [7:0] mem [DEPTH];
    logic [7:0] rx_byte;
    assign rx_byte = {shift_reg[6:0], sda_s};

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    // Only written when data is acked; no reset, the cells keep their contents
    // Inhibit is sampled on the last data bit, so a late change cannot tear a byte
    always_ff @(posedge sys_clk) begin
        if (clk_en && scl_rise && state_reg == EIS_WDATA && bit_reg == 4'h7 && !inhibit_s) begin
            mem[addr_reg[$clog2(DEPTH)-1:0]] <= rx_byte;
        end
    end

    // Protocol state machine, MSB-first shifting on rising clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= EIS_IDLE;
            bit_reg <= EIS_BIT_RESET;
            shift_reg <= EIS_BYTE_RESET;
            tx_reg <= EIS_BYTE_RESET;
            ack_reg <= 1'b0;
            wrote_reg <= 1'b0;
            master_nack_reg <= 1'b0;
            addr_cnt_reg <= 2'h0;
            addr_reg <= EIS_ADDR_RESET;
            program_start <= 1'b0;
        end else if (clk_en) begin
            program_start <= 1'b0;
            if (start_det) begin
                // Repeated start keeps the address for random reads
                state_reg <= EIS_SELECT;
                // One below zero: the clock fall that closes the Start
                // brings the count to zero before the first data bit
                bit_reg <= EIS_BIT_RESET - 4'h1;
                ack_reg <= 1'b0;
            end else if (stop_det) begin
                program_start <= wrote_reg;
                wrote_reg <= 1'b0;
                state_reg <= EIS_IDLE;
                ack_reg <= 1'b0;
            end else if (state_reg != EIS_IDLE && scl_rise) begin
                if (bit_reg == EIS_ACK_SLOT) begin
                    master_nack_reg <= sda_s;
                end else begin
                    shift_reg <= rx_byte;
                end
                if (bit_reg == 4'h7) begin
                    unique case (state_reg)
                        EIS_SELECT: begin
                            ack_reg <= sel_match(rx_byte, strap_s);
                            addr_cnt_reg <= 2'h0;
                            if (!sel_match(rx_byte, strap_s)) begin
                                state_reg <= EIS_IDLE;
                            end else if (rx_byte[EIS_RW_BIT]) begin
                                state_reg <= EIS_RDATA;
                                ack_reg <= 1'b1;
                            end else begin
                                state_reg <= EIS_ADDR;
                            end
                        end
                        EIS_ADDR: begin
                            ack_reg <= 1'b1;
                            addr_reg <= {addr_reg[7:0], rx_byte};
                            addr_cnt_reg <= addr_cnt_reg + 2'h1;
                            if (addr_cnt_reg + 2'h1 == EIS_ADDR_BYTES) begin
                                state_reg <= EIS_WDATA;
                            end
                        end
                        EIS_WDATA: begin
                            ack_reg <= !inhibit_s;
                            if (!inhibit_s) begin
                                wrote_reg <= 1'b1;
                                addr_reg <= addr_reg + 16'h0001;
                            end
                        end
                        EIS_RDATA: ack_reg <= 1'b0;
                        default: state_reg <= EIS_IDLE;
                    endcase
                end
            end else if (state_reg != EIS_IDLE && scl_fall) begin
                if (bit_reg == EIS_ACK_SLOT) begin
                    bit_reg <= EIS_BIT_RESET;
                    ack_reg <= 1'b0;
                    // Every read byte loads here, after the select ack or the master's ack
                    if (state_reg == EIS_RDATA) begin
                        if (master_nack_reg) begin
                            state_reg <= EIS_IDLE;
                        end
                        tx_reg <= mem[addr_reg[$clog2(DEPTH)-1:0]];
                        addr_reg <= addr_reg + 16'h0001;
                    end
                end else begin
                    bit_reg <= bit_reg + 4'h1;
                    if (state_reg == EIS_RDATA && bit_reg != 4'h7) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Open-drain data pin
    // ----------------------------------------
    // Ack is held across the whole ninth period, read bits across eight
    // Read bits move only after the clock fall is seen, well before the next rise
    logic drive_low;
    always_comb begin
        drive_low = 1'b0;
        if (bit_reg == EIS_ACK_SLOT) begin
            drive_low = ack_reg;
        end else if (state_reg == EIS_RDATA && !ack_reg) begin
            drive_low = !tx_reg[7];
        end
    end
    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    // The enable alone moves the line; the level behind it stays low
    assign sda_out = 1'b0;
    assign sda_oe = drive_low;
    assign selected = (state_reg != EIS_IDLE) && (state_reg != EIS_SELECT);
endmodule

/* File: verif/eis_slave_props.sv */
// Port checks for the two-wire memory slave
`timescale 1ns/100ps
module eis_slave_props
    import eis_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_inhibit_input,
    input wire logic program_start,
    input wire logic selected
);
    // ----
    // Bus checks
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Start: data falls while the clock stands high
    sequence start_seen;
        scl_in && $fell(sda_in);
    endsequence
    chk_never_high: assert property (sda_out == 1'b0) else $error("data driven high");
    chk_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !selected && !program_start) else $error("reset");
    chk_pulse_once: assert property (program_start |=> !program_start) else $error("long pulse");
    chk_ack_bounded: assert property ($rose(sda_oe) |-> ##[1:120] $fell(sda_oe)) else $error("line held");
    chk_inhibit_prog: assert property (program_start |-> !$past(write_inhibit_input, 4)) else $error("inhibit");
    chk_enable_freeze: assert property (!clk_en |=> $stable(sda_oe) && $stable(selected)) else $error("frozen");
    chk_start_quiet: assert property (start_seen |=> !sda_oe [*8]) else $error("pull after start");
    chk_scl_low_move: assert property ($changed(sda_oe) |-> !scl_in) else $error("moved in high");
endmodule
bind eis_slave eis_slave_props u_props (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_inhibit_input(write_inhibit_input),
    .program_start(program_start), .selected(selected));

/* File: verif/eis_bus_master.sv */
// Bus master model for the serial clock and data line
`timescale 1ns/100ps
module eis_bus_master (
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    // Idle: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Start, also a repeated start; leaves the clock low
    task automatic start();
        #50 sda_rel = 1'b1;
        #50 scl = 1'b1;
        #50 sda_rel = 1'b0;
        #50 scl = 1'b0;
    endtask
    // Eight bits MSB first, then our own level in slot nine
    task automatic byte_io(input logic [7:0] tx, input logic ain, output logic [7:0] rx, output logic aout);
        logic [8:0] sh;
        for (int i = 8; i >= 0; i--) begin
            #50 sda_rel = (i > 0) ? tx[i-1] : ain;
            #75 scl = 1'b1;
            #50 sh = {sh[7:0], sda};
            #25 scl = 1'b0;
        end
        {rx, aout} = sh;
    endtask
    // Stop; the clock then stands high until the next frame
    task automatic stop();
        #50 sda_rel = 1'b0;
        #50 scl = 1'b1;
        #50 sda_rel = 1'b1;
    endtask
endmodule

/* File: verif/test_eis_slave.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/100ps
module test_eis_slave
    import eis_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic winh = 1'b0;
    logic [2:0] straps = 3'h5;
    logic [7:0] rx;
    logic ack;
    int n_fail = 0;
    int total_checks = 0;
    int n_prog = 0;
    wire scl, sda_rel, sda_oe, prog, sel_o;
    // Pulled-up line, low when either party pulls
    wire sda = sda_rel & ~sda_oe;
    eis_bus_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    eis_slave uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .strap_select_bit0(straps[0]), .strap_select_bit1(straps[1]),
        .strap_select_bit2(straps[2]), .write_inhibit_input(winh), .program_start(prog), .selected(sel_o));
    // Clock, program pulse count, and a watchdog well past the run length
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) n_prog <= n_prog + (prog === 1'b1);
    initial begin
        #400000 n_fail++;
        end_of_test();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Send one byte and expect level e in slot nine
    task automatic xb(input logic [7:0] tx, input logic e);
        m.byte_io(tx, 1'b1, rx, ack);
        check({7'h0, ack}, {7'h0, e});
    endtask
    // Start, select for write, two address bytes
    task automatic addr(input logic [15:0] a);
        m.start();
        xb({EIS_TYPE_ID, straps, 1'b0}, 1'b0);
        xb(a[15:8], 1'b0);
        xb(a[7:0], 1'b0);
    endtask
    // Byte write; with inhibit high the data byte is refused and nothing programs
    task automatic t_write(input logic [15:0] a, input logic [7:0] d);
        int p0;
        p0 = n_prog;
        addr(a);
        check({7'h0, sel_o}, 8'h01);
        xb(d, winh);
        m.stop();
        repeat (8) @(posedge sys_clk);
        check(8'(n_prog - p0), {7'h0, ~winh});
    endtask
    // Random read through a repeated start, ended by no-ack
    task automatic t_read(input logic [15:0] a, input logic [7:0] d);
        addr(a);
        m.start();
        xb({EIS_TYPE_ID, straps, 1'b1}, 1'b0);
        m.byte_io(8'hFF, 1'b1, rx, ack);
        check(rx, d);
        m.stop();
        repeat (8) @(posedge sys_clk);
    endtask
    // Flip each strap bit and one type bit: no ack, bus ignored
    task automatic t_mismatch();
        for (int i = 0; i < 4; i++) begin
            m.start();
            xb({EIS_TYPE_ID, straps, 1'b0} ^ (8'h02 << i), 1'b1);
            xb(8'h00, 1'b1);
            check({7'h0, sel_o}, 8'h00);
            m.stop();
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 clk_en = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 clk_en = 1'b1;
        t_write(16'h0123, 8'hA5);
        // Step off the clock edge so the next frame keeps the same offset
        #1 t_read(16'h0123, 8'hA5);
        #1 winh = 1'b1;
        t_write(16'h0124, 8'h3C);
        #1 winh = 1'b0;
        t_mismatch();
        end_of_test();
    end
endmodule
